// File: test/io_pin_timing_reference_select_bench.sv
// Purpose: self-checking bench for the timing reference selector
// Assumes: CLK 50 MHz, link clocks of 160 ns from the model
// Notes: every control word is written and read back once
`timescale 1ns/1ps
module io_pin_timing_reference_select_bench;
  // bus master side
  logic clk, reset, awvalid, wvalid, arvalid, bready, rready, go;
  logic [4:0] awaddr, araddr;
  logic [31:0] wdata, d;
  logic [3:0] wstrb;
  logic [7:0] pat;
  wire awready, wready, bvalid, arready, rvalid;
  wire [1:0] bresp, rresp, tls, tfs, rfs;
  wire [31:0] rdata;
  // link pins and decoded outputs
  wire done, rx_clk, tx_clk, pos, neg, pos_q, neg_q, en;
  wire [4:0] tlv, tfv, rlv, rfv;
  // bookkeeping
  int n_errors, compares, i, j, t;
  logic [1:0] r;
  logic [10:0] c;
  logic [25:0] e;
  // line mode code beside the enable it decodes to
  logic [3:0] rows [8] = '{4'h0, 4'h3, 4'h5, 4'h7,
    4'h8, 4'ha, 4'hc, 4'he};

  // five address bits so that word 0x10 is unmapped
  iopin_timing_ref #(.ADDR_WIDTH(5)) iopin_timing_ref_inst (
    .CLK(clk), .RESET(reset), .S_AXI_AWADDR(awaddr),
    .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready),
    .S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wvalid),
    .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid),
    .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr),
    .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
    .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid),
    .S_AXI_RREADY(rready), .RX_LINE_CLK_IN(rx_clk), .TX_CLK_IN(tx_clk),
    .RX_LINE_POS_DATA(pos), .RX_LINE_NEG_VIOLATION(neg),
    .RX_LINE_POS_Q(pos_q), .RX_LINE_NEG_Q(neg_q),
    .LINE_IFACE_ENABLED(en), .TX_LINE_VALID(tlv),
    .TX_FRAMER_VALID(tfv), .RX_LINE_VALID(rlv), .RX_FRAMER_VALID(rfv),
    .TX_LINE_SRC(tls), .TX_FRAMER_SRC(tfs), .RX_FRAMER_SRC(rfs));
  iopin_link_model link_inst (.go(go), .pat(pat), .done(done),
    .rx_clk(rx_clk), .tx_clk(tx_clk), .pos(pos), .neg(neg));

  // expected {sources, references} for a control word
  function automatic [25:0] exp_ref(input [10:0] w, input n);
    logic lt, by, ra, fa;
    logic [2:0] lb;
    logic [4:0] tl, tf, rf;
    logic [1:0] sr;
    lt = w[0];
    lb = w[3:1];
    by = w[4];
    ra = lt || lb == 3'h2 || lb == 3'h3 || lb == 3'h6;
    fa = lt || lb == 3'h3 || lb == 3'h4 || (lb == 3'h1 && !n);
    if (!w[8]) tl = (lt || lb == 3'h4) ? 5'h07 : (lb == 3'h2 ||
      lb == 3'h3) ? 5'h03 : (lb == 3'h6) ? 5'h01 : 5'h05;
    else tl = ra ? (n ? 5'h00 : 5'h08) : (by ? 5'h10 : 5'h00);
    if (!w[9]) tf = fa ? 5'h07 : (lb == 3'h6) ? 5'h06 :
      (lb == 3'h2) ? 5'h04 : 5'h05;
    else tf = (lt || lb == 3'h3) ? (n ? 5'h00 : 5'h08) :
      (by ? 5'h10 : 5'h00);
    if (!w[10]) rf = fa ? 5'h07 : (lb == 3'h6) ? 5'h06 :
      (lb == 3'h2) ? 5'h03 : 5'h02;
    else rf = (!lt && (lb == 3'h4 || lb == 3'h6)) ?
      (by ? 5'h10 : 5'h00) : (n ? 5'h00 : 5'h08);
    sr = (!lt && (lb[2] || (lb == 3'h1 && !n))) ? {1'b0, by} :
      (n ? 2'h3 : 2'h2);
    return {sr, (lt || lb == 3'h3) ? (n ? 2'h3 : 2'h2) : {1'b0, by},
      ra ? (n ? 2'h3 : 2'h2) : {1'b0, by},
      rf, n ? 5'h00 : 5'h08, tf, tl};
  endfunction

  // compare and count, report a mismatch at once
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      n_errors++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  // one write; readies judged before the edge they are taken at
  task automatic wr(input [4:0] a, input [31:0] v, input [3:0] s);
    logic ta, tw, tb;
    awaddr <= a;
    wdata <= v;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    do begin
      @(negedge clk);
      ta = awvalid & awready;
      tw = wvalid & wready;
      tb = bvalid;
      r = bresp;
      @(posedge clk);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
    end while (!tb);
  endtask

  // one read, data taken at the edge rvalid is seen
  task automatic rd(input [4:0] a);
    logic ta, tr;
    araddr <= a;
    arvalid <= 1'b1;
    do begin
      @(negedge clk);
      ta = arvalid & arready;
      tr = rvalid;
      d = rdata;
      r = rresp;
      @(posedge clk);
      if (ta) arvalid <= 1'b0;
    end while (!tr);
  endtask

  // one far-side frame, then time for the synchronisers
  task automatic frame(input [7:0] p);
    pat <= p;
    go <= 1'b1;
    t = 0;
    while (!done && t < 100) begin
      @(posedge clk);
      t++;
    end
    go <= 1'b0;
    repeat (6) @(posedge clk);
  endtask

  task automatic final_report;
    $display("compares %0d, mismatches %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // watchdog: tests need about 17k cycles, this allows 75k
  initial begin
    #1500000;
    n_errors++;
    final_report;
  end

  initial begin
    {reset, bready, rready, awvalid, wvalid, arvalid, go} = 7'h70;
    {awaddr, araddr, wstrb, pat} = 22'h0;
    wdata = 32'h0;
    repeat (8) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    chk({rfv, rlv, tfv, tlv}, 32'h120a5);
    chk({rfs, tfs, tls}, 32'h20);
    rd(5'h0c);
    chk(d, 32'h0);
    $display("reset test done");
    // every mode, loopback, bypass and select per line mode row
    for (i = 0; i < 8; i++) begin
      for (j = 0; j < 256; j++) begin
        c = {j[7:5], rows[i][3:1], j[4:0]};
        e = exp_ref(c, rows[i][0]);
        wr(5'h00, {21'h0, c}, 4'hf);
        chk(r, 2'h0);
        chk(en, rows[i][0]);
        chk(tlv, e[4:0]);
        chk(tfv, e[9:5]);
        chk(rlv, e[14:10]);
        chk(rfv, e[19:15]);
        chk({rfs, tfs, tls}, e[25:20]);
        rd(5'h04);
        chk(d, {11'h0, rows[i][0], e[19:0]});
        rd(5'h08);
        chk(d, {26'h0, e[25:20]});
        rd(5'h00);
        chk(d, {21'h0, c});
      end
    end
    $display("mode table done");
    // lane 0 masked, read-only and unmapped words
    wr(5'h00, 32'h0, 4'hf);
    wr(5'h00, 32'h7ff, 4'he);
    wr(5'h04, 32'hffffffff, 4'hf);
    chk(r, 2'h0);
    wr(5'h10, 32'h0, 4'hf);
    chk(r, 2'h2);
    rd(5'h10);
    chk(d, 32'h0);
    chk(r, 2'h2);
    rd(5'h00);
    chk(d, 32'h700);
    $display("bus corner test done");
    // line unit off: bits captured by the link clock
    wr(5'h00, 32'h0, 4'hf);
    frame(8'ha5);
    rd(5'h0c);
    chk(d, 32'h00080801);
    chk({neg_q, pos_q}, 2'h1);
    // line unit on: pins unused, capture holds
    wr(5'h00, 32'h20, 4'hf);
    frame(8'h5a);
    rd(5'h0c);
    chk(d, 32'h00101001);
    chk({neg_q, pos_q}, 2'h1);
    $display("link test done");
    // second reset in mid-run clears control and link state
    reset <= 1'b1;
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    chk({rfv, rlv, tfv, tlv}, 32'h120a5);
    chk(en, 1'b0);
    rd(5'h0c);
    chk(d, 32'h0);
    rd(5'h00);
    chk(d, 32'h0);
    $display("mid-run reset test done");
    final_report;
  end
endmodule // io_pin_timing_reference_select_bench

// File: test/iopin_link_model.sv
// Purpose: far-side line logic driving link clocks and rx data
// Assumes: link clocks stand still between frames
// Notes: data moves at the clock fall, centred on the rise
`timescale 1ns/1ps
module iopin_link_model (
  // frame request
  input wire go,
  input wire [7:0] pat,
  output logic done,
  // pins toward the device
  output logic rx_clk,
  output logic tx_clk,
  output logic pos,
  output logic neg
);
  int k;
  // one eight-bit frame per request; 7 ns skews us off CLK
  initial begin
    {done, rx_clk, tx_clk, pos, neg} = 5'h01;
    #7;
    forever begin
      if (go && !done) begin
        for (k = 0; k < 8; k++) begin
          pos = pat[k];
          neg = ~pat[k];
          #40 tx_clk = 1'b1;
          #40 rx_clk = 1'b1;
          #40 tx_clk = 1'b0;
          #40 rx_clk = 1'b0;
        end
        done = 1'b1;
      end else begin
        // idle data toggles so no stale bit looks valid
        if (!go) done = 1'b0;
        pos = ~pos;
        neg = ~neg;
        #20;
      end
    end
  end
endmodule // iopin_link_model

// File: test/iopin_timing_ref_chk.sv
// Purpose: port checks of the timing reference selector
// Assumes: one CLK domain, RESET synchronous active high
// Notes: sees top ports only, bound below
`timescale 1ns/1ps
module iopin_timing_ref_chk (
  // clock and reset
  input wire CLK,
  input wire RESET,
  // write handshake
  input wire S_AXI_AWVALID,
  input wire S_AXI_AWREADY,
  input wire S_AXI_WVALID,
  input wire S_AXI_WREADY,
  input wire S_AXI_BVALID,
  // decoded outputs
  input wire LINE_IFACE_ENABLED,
  input wire RX_LINE_POS_Q,
  input wire [4:0] TX_LINE_VALID,
  input wire [4:0] TX_FRAMER_VALID,
  input wire [4:0] RX_LINE_VALID,
  input wire [4:0] RX_FRAMER_VALID,
  input wire [1:0] TX_LINE_SRC,
  input wire [1:0] TX_FRAMER_SRC,
  input wire [1:0] RX_FRAMER_SRC
);
  default clocking @(posedge CLK); endclocking
  default disable iff (RESET);
  // both halves of a write taken at one edge
  sequence s_taken;
    S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY;
  endsequence
  // answer raised, new requests held off meanwhile
  sequence s_answer;
    S_AXI_BVALID && !S_AXI_AWREADY && !S_AXI_WREADY;
  endsequence
  a_write_answer: assert property (s_taken |=> s_answer)
    else $error("write answer late");
  a_rx_line_ref: assert property (
    RX_LINE_VALID == (LINE_IFACE_ENABLED ? 5'h00 : 5'h08))
    else $error("rx line reference wrong");
  a_tx_line_kind: assert property ((|TX_LINE_VALID[2:0]) |->
    TX_LINE_VALID[0] && TX_LINE_VALID[4:3] == 2'h0)
    else $error("tx line clock kind mixed");
  a_tx_framer_kind: assert property ((|TX_FRAMER_VALID[2:0]) |->
    TX_FRAMER_VALID[2] && TX_FRAMER_VALID[4:3] == 2'h0)
    else $error("tx framer clock kind mixed");
  a_rx_framer_kind: assert property ((|RX_FRAMER_VALID[2:0]) |->
    RX_FRAMER_VALID[1] && RX_FRAMER_VALID[4:3] == 2'h0)
    else $error("rx framer clock kind mixed");
  a_tx_line_src: assert property (TX_LINE_VALID[3] |->
    TX_LINE_SRC == 2'h2 && !LINE_IFACE_ENABLED)
    else $error("tx line source wrong");
  a_tx_framer_src: assert property (
    TX_FRAMER_VALID[4] |-> TX_FRAMER_SRC == 2'h1)
    else $error("tx framer source wrong");
  a_rx_framer_src: assert property (
    RX_FRAMER_VALID[4] |-> RX_FRAMER_SRC == 2'h1)
    else $error("rx framer source wrong");
  // references move only with a completed control write
  a_valid_steady: assert property ($changed({TX_LINE_VALID,
    TX_FRAMER_VALID, RX_FRAMER_VALID}) |-> $rose(S_AXI_BVALID))
    else $error("references moved without a write");
  a_capture_hold: assert property ($changed(RX_LINE_POS_Q) |->
    !$past(LINE_IFACE_ENABLED))
    else $error("capture while line unit on");
endmodule // iopin_timing_ref_chk

bind iopin_timing_ref iopin_timing_ref_chk chk_inst (
  .CLK, .RESET, .S_AXI_AWVALID, .S_AXI_AWREADY, .S_AXI_WVALID,
  .S_AXI_WREADY, .S_AXI_BVALID, .LINE_IFACE_ENABLED, .RX_LINE_POS_Q,
  .TX_LINE_VALID, .TX_FRAMER_VALID, .RX_LINE_VALID, .RX_FRAMER_VALID,
  .TX_LINE_SRC, .TX_FRAMER_SRC, .RX_FRAMER_SRC
);

// File: verilog/iopin_defines.vh
// Purpose: shared constants for the I/O pin timing reference selector
// Assumes: AXI4-Lite register access, 32-bit data, byte addresses
// Notes: definitions only, no logic
`ifndef IOPIN_DEFINES_VH
`define IOPIN_DEFINES_VH

// register byte offsets
`define REG_CTRL_OFS 4'h0
`define REG_VALID_OFS 4'h4
`define REG_SOURCE_OFS 4'h8
`define REG_LINK_OFS 4'hc

// control register field positions
`define CTRL_LOOP_TIMED 0
`define CTRL_LB_LO 1
`define CTRL_LB_HI 3
`define CTRL_BYPASS 4
`define CTRL_MODE_LO 5
`define CTRL_MODE_HI 7
`define CTRL_TXL_SEL 8
`define CTRL_TXF_SEL 9
`define CTRL_RXF_SEL 10
`define CTRL_WIDTH 11
`define CTRL_RESET 11'h000

// loopback select codes
`define LB_NONE 3'h0
`define LB_ANALOG 3'h1
`define LB_LINE 3'h2
`define LB_PAYLOAD 3'h3
`define LB_DIAG 3'h4
`define LB_LINE_DIAG 3'h6

// valid-reference vector bit positions
`define REF_TX_LINE_CLK_OUT 0
`define REF_RX_CLK_OUT 1
`define REF_TX_CLK_OUT 2
`define REF_RX_LINE_CLK_IN 3
`define REF_TX_CLK_IN 4
`define REF_WIDTH 5

// functional clock source codes
`define SRC_RATE_ADAPTER 2'h0
`define SRC_TX_CLK_IN 2'h1
`define SRC_RX_LINE_CLK_IN 2'h2
`define SRC_RX_LINE_UNIT 2'h3

// axi response codes
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// File: verilog/iopin_timing_ref.v
// Purpose: per-port I/O pin timing reference selection with register access
// Assumes: CLK 50 MHz, RESET synchronous active high, AXI4-Lite slave
// Notes: link clock pins are sampled by CLK, never used as clocks here
//
// Chosen here: the register addresses and the AXI4-Lite slave port.
`timescale 1ns/1ps
`include "iopin_defines.vh"

module iopin_timing_ref #(
  parameter ADDR_WIDTH = 4
) (
  // clock and reset
  input wire CLK,
  input wire RESET,
  // axi4-lite write address
  input wire [ADDR_WIDTH-1:0] S_AXI_AWADDR,
  input wire S_AXI_AWVALID,
  output wire S_AXI_AWREADY,
  // axi4-lite write data
  input wire [31:0] S_AXI_WDATA,
  input wire [3:0] S_AXI_WSTRB,
  input wire S_AXI_WVALID,
  output wire S_AXI_WREADY,
  // axi4-lite write response
  output wire [1:0] S_AXI_BRESP,
  output wire S_AXI_BVALID,
  input wire S_AXI_BREADY,
  // axi4-lite read address
  input wire [ADDR_WIDTH-1:0] S_AXI_ARADDR,
  input wire S_AXI_ARVALID,
  output wire S_AXI_ARREADY,
  // axi4-lite read data
  output wire [31:0] S_AXI_RDATA,
  output wire [1:0] S_AXI_RRESP,
  output wire S_AXI_RVALID,
  input wire S_AXI_RREADY,
  // clock pins from outside, sampled by CLK
  input wire RX_LINE_CLK_IN,
  input wire TX_CLK_IN,
  // receive line data pins
  input wire RX_LINE_POS_DATA,
  input wire RX_LINE_NEG_VIOLATION,
  // captured receive line data
  output wire RX_LINE_POS_Q,
  output wire RX_LINE_NEG_Q,
  // decoded mode
  output wire LINE_IFACE_ENABLED,
  // valid timing reference vectors per pin group
  output wire [4:0] TX_LINE_VALID,
  output wire [4:0] TX_FRAMER_VALID,
  output wire [4:0] RX_LINE_VALID,
  output wire [4:0] RX_FRAMER_VALID,
  // functional clock source per pin group
  output wire [1:0] TX_LINE_SRC,
  output wire [1:0] TX_FRAMER_SRC,
  output wire [1:0] RX_FRAMER_SRC
);

  // control register holding mode and timing select bits
  reg [10:0] ctrl_reg;
  reg [10:0] ctrl_next;

  // write channel state: each half is held until both have arrived
  reg aw_got_reg; // write address captured
  reg w_got_reg; // write data captured
  reg [ADDR_WIDTH-1:0] aw_addr_reg;
  reg [31:0] w_data_reg;
  reg [3:0] w_strb_reg;
  reg bvalid_reg;
  reg [1:0] bresp_reg;

  // read channel state
  reg rvalid_reg;
  reg [31:0] rdata_reg;
  reg [1:0] rresp_reg;

  // synchronisers for pins from outside the CLK domain
  reg rlclk_s1_reg, rlclk_s2_reg, rlclk_d_reg;
  reg tclk_s1_reg, tclk_s2_reg, tclk_d_reg;
  reg pos_s1_reg, pos_s2_reg;
  reg neg_s1_reg, neg_s2_reg;

  // captured line data and activity counters
  reg pos_q_reg, neg_q_reg;
  reg [7:0] rlclk_cnt_reg;
  reg [7:0] tclk_cnt_reg;

  // decoded results from the table module
  wire line_en;
  wire [4:0] txl_valid, txf_valid, rxl_valid, rxf_valid;
  wire [1:0] txl_src, txf_src, rxf_src;

  // field views of the control register
  wire loop_timed = ctrl_reg[`CTRL_LOOP_TIMED];
  wire [2:0] loopback_select = ctrl_reg[`CTRL_LB_HI:`CTRL_LB_LO];
  wire rate_adapter_bypass = ctrl_reg[`CTRL_BYPASS];
  wire [2:0] line_mode_field = ctrl_reg[`CTRL_MODE_HI:`CTRL_MODE_LO];
  wire tx_line_timing_sel = ctrl_reg[`CTRL_TXL_SEL];
  wire tx_framer_timing_sel = ctrl_reg[`CTRL_TXF_SEL];
  wire rx_framer_timing_sel = ctrl_reg[`CTRL_RXF_SEL];

  // mode decode, purely combinational from control bits
  valid_ref_table valid_ref_table_inst (
    .loop_timed(loop_timed),
    .loopback_select(loopback_select),
    .rate_adapter_bypass(rate_adapter_bypass),
    .line_mode_field(line_mode_field),
    .tx_line_timing_sel(tx_line_timing_sel),
    .tx_framer_timing_sel(tx_framer_timing_sel),
    .rx_framer_timing_sel(rx_framer_timing_sel),
    .line_iface_enabled(line_en),
    .tx_line_valid(txl_valid),
    .tx_framer_valid(txf_valid),
    .rx_line_valid(rxl_valid),
    .rx_framer_valid(rxf_valid),
    .tx_line_src(txl_src),
    .tx_framer_src(txf_src),
    .rx_framer_src(rxf_src)
  );

  // handshake outputs; no new address is taken while a response waits
  assign S_AXI_AWREADY = ~aw_got_reg & ~bvalid_reg;
  assign S_AXI_WREADY = ~w_got_reg & ~bvalid_reg;
  assign S_AXI_BVALID = bvalid_reg;
  assign S_AXI_BRESP = bresp_reg;
  assign S_AXI_ARREADY = ~rvalid_reg;
  assign S_AXI_RVALID = rvalid_reg;
  assign S_AXI_RDATA = rdata_reg;
  assign S_AXI_RRESP = rresp_reg;

  // handshake events
  wire aw_take = S_AXI_AWVALID & S_AXI_AWREADY;
  wire w_take = S_AXI_WVALID & S_AXI_WREADY;
  wire ar_take = S_AXI_ARVALID & S_AXI_ARREADY;

  // address and data seen this cycle, from the bus or the holding regs
  wire have_aw = aw_got_reg | aw_take;
  wire have_w = w_got_reg | w_take;
  wire [ADDR_WIDTH-1:0] wr_addr = aw_got_reg ? aw_addr_reg : S_AXI_AWADDR;
  wire [31:0] wr_data = w_got_reg ? w_data_reg : S_AXI_WDATA;
  wire [3:0] wr_strb = w_got_reg ? w_strb_reg : S_AXI_WSTRB;
  wire wr_fire = have_aw & have_w & ~bvalid_reg;

  // address decode on the aligned word, low two bits ignored
  wire [ADDR_WIDTH-1:0] wr_word = {wr_addr[ADDR_WIDTH-1:2], 2'b00};
  wire [ADDR_WIDTH-1:0] rd_word = {S_AXI_ARADDR[ADDR_WIDTH-1:2], 2'b00};
  wire wr_ctrl = (wr_word == `REG_CTRL_OFS);
  // read-only words accept a write silently; unmapped words are an error
  wire wr_mapped = wr_ctrl | (wr_word == `REG_VALID_OFS) |
    (wr_word == `REG_SOURCE_OFS) | (wr_word == `REG_LINK_OFS);

  // byte-lane mask built from the write strobes
  wire [31:0] lane_mask;
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi = gi + 1) begin : g_lane
      assign lane_mask[gi*8 +: 8] = {8{wr_strb[gi]}};
    end
  endgenerate

  // control register next value with byte-lane merge
  always @* begin
    ctrl_next = ctrl_reg;
    if (wr_fire & wr_ctrl) begin
      // only the low eleven bits exist, the rest are dropped
      ctrl_next = (ctrl_reg & ~lane_mask[10:0]) |
        (wr_data[10:0] & lane_mask[10:0]);
    end
  end

  // read mux; unimplemented bits read as zero
  reg [31:0] rd_value;
  reg rd_mapped;
  always @* begin
    rd_value = 32'h00000000;
    rd_mapped = 1'b1;
    case (rd_word)
      `REG_CTRL_OFS: begin
        rd_value[10:0] = ctrl_reg;
      end
      `REG_VALID_OFS: begin
        rd_value[4:0] = txl_valid;
        rd_value[9:5] = txf_valid;
        rd_value[14:10] = rxl_valid;
        rd_value[19:15] = rxf_valid;
        rd_value[20] = line_en; // derived, never written
      end
      `REG_SOURCE_OFS: begin
        rd_value[1:0] = txl_src;
        rd_value[3:2] = txf_src;
        rd_value[5:4] = rxf_src;
      end
      `REG_LINK_OFS: begin
        rd_value[0] = pos_q_reg;
        rd_value[1] = neg_q_reg;
        rd_value[15:8] = rlclk_cnt_reg;
        rd_value[23:16] = tclk_cnt_reg;
      end
      default: begin
        rd_mapped = 1'b0;
      end
    endcase
  end

  // write channel: capture halves, fire once both are present
  always @(posedge CLK) begin
    if (RESET) begin
      ctrl_reg <= `CTRL_RESET;
      aw_got_reg <= 1'b0;
      w_got_reg <= 1'b0;
      aw_addr_reg <= {ADDR_WIDTH{1'b0}};
      w_data_reg <= 32'h00000000;
      w_strb_reg <= 4'h0;
      bvalid_reg <= 1'b0;
      bresp_reg <= `RESP_OKAY;
    end else begin
      ctrl_reg <= ctrl_next;
      if (wr_fire) begin
        // both halves used up, response raised next cycle
        aw_got_reg <= 1'b0;
        w_got_reg <= 1'b0;
        bvalid_reg <= 1'b1;
        bresp_reg <= wr_mapped ? `RESP_OKAY : `RESP_SLVERR;
      end else begin
        // park whichever half arrived first
        if (aw_take) begin
          aw_got_reg <= 1'b1;
          aw_addr_reg <= S_AXI_AWADDR;
        end
        if (w_take) begin
          w_got_reg <= 1'b1;
          w_data_reg <= S_AXI_WDATA;
          w_strb_reg <= S_AXI_WSTRB;
        end
        if (bvalid_reg & S_AXI_BREADY)
          bvalid_reg <= 1'b0;
      end
    end
  end

  // read channel: one cycle from address to data
  always @(posedge CLK) begin
    if (RESET) begin
      rvalid_reg <= 1'b0;
      rdata_reg <= 32'h00000000;
      rresp_reg <= `RESP_OKAY;
    end else if (ar_take) begin
      rvalid_reg <= 1'b1;
      rdata_reg <= rd_value;
      rresp_reg <= rd_mapped ? `RESP_OKAY : `RESP_SLVERR;
    end else if (rvalid_reg & S_AXI_RREADY) begin
      rvalid_reg <= 1'b0;
    end
  end

  // two-stage synchronisers; the first stage feeds only the second
  always @(posedge CLK) begin
    if (RESET) begin
      rlclk_s1_reg <= 1'b0;
      rlclk_s2_reg <= 1'b0;
      tclk_s1_reg <= 1'b0;
      tclk_s2_reg <= 1'b0;
      pos_s1_reg <= 1'b0;
      pos_s2_reg <= 1'b0;
      neg_s1_reg <= 1'b0;
      neg_s2_reg <= 1'b0;
    end else begin
      rlclk_s1_reg <= RX_LINE_CLK_IN;
      rlclk_s2_reg <= rlclk_s1_reg;
      tclk_s1_reg <= TX_CLK_IN;
      tclk_s2_reg <= tclk_s1_reg;
      pos_s1_reg <= RX_LINE_POS_DATA;
      pos_s2_reg <= pos_s1_reg;
      neg_s1_reg <= RX_LINE_NEG_VIOLATION;
      neg_s2_reg <= neg_s1_reg;
    end
  end

  // rising-edge detect on the synchronised clock levels
  wire rlclk_rise = rlclk_s2_reg & ~rlclk_d_reg;
  wire tclk_rise = tclk_s2_reg & ~tclk_d_reg;

  // rx line data taken on its own clock edge, only with the line unit off;
  // data and clock share one sync delay, costing 2-3 CLK of latency
  always @(posedge CLK) begin
    if (RESET) begin
      rlclk_d_reg <= 1'b0;
      tclk_d_reg <= 1'b0;
      pos_q_reg <= 1'b0;
      neg_q_reg <= 1'b0;
      rlclk_cnt_reg <= 8'h00;
      tclk_cnt_reg <= 8'h00;
    end else begin
      rlclk_d_reg <= rlclk_s2_reg;
      tclk_d_reg <= tclk_s2_reg;
      if (rlclk_rise & ~line_en) begin
        pos_q_reg <= pos_s2_reg;
        neg_q_reg <= neg_s2_reg;
      end
      // free-running activity counters, wrap at 256
      if (rlclk_rise)
        rlclk_cnt_reg <= rlclk_cnt_reg + 8'h01;
      if (tclk_rise)
        tclk_cnt_reg <= tclk_cnt_reg + 8'h01;
    end
  end

  // decoded outputs track the control register combinationally
  assign LINE_IFACE_ENABLED = line_en;
  assign TX_LINE_VALID = txl_valid;
  assign TX_FRAMER_VALID = txf_valid;
  assign RX_LINE_VALID = rxl_valid;
  assign RX_FRAMER_VALID = rxf_valid;
  // far side picks its reference from these vectors
  assign TX_LINE_SRC = txl_src;
  assign TX_FRAMER_SRC = txf_src;
  assign RX_FRAMER_SRC = rxf_src;
  assign RX_LINE_POS_Q = pos_q_reg;
  assign RX_LINE_NEG_Q = neg_q_reg;
endmodule // iopin_timing_ref

// File: verilog/valid_ref_table.v
// Purpose: decode port mode into valid timing references and clock sources
// Assumes: purely combinational, inputs come from control flip-flops
// Notes: vector bits follow the REF_ positions of the shared header
`timescale 1ns/1ps
`include "iopin_defines.vh"

module valid_ref_table (
  // port mode
  input wire loop_timed,
  input wire [2:0] loopback_select,
  input wire rate_adapter_bypass,
  input wire [2:0] line_mode_field,
  // group timing selects
  input wire tx_line_timing_sel,
  input wire tx_framer_timing_sel,
  input wire rx_framer_timing_sel,
  // decoded results
  output wire line_iface_enabled,
  output reg [4:0] tx_line_valid,
  output reg [4:0] tx_framer_valid,
  output wire [4:0] rx_line_valid,
  output reg [4:0] rx_framer_valid,
  output reg [1:0] tx_line_src,
  output reg [1:0] tx_framer_src,
  output reg [1:0] rx_framer_src
);

  // output-clock shorthands: TL=bit0, RO=bit1, TO=bit2
  localparam [4:0] V_NONE = 5'h00;
  localparam [4:0] V_TL = 5'h01;
  localparam [4:0] V_RO = 5'h02;
  localparam [4:0] V_TO = 5'h04;
  localparam [4:0] V_RL = 5'h08;
  localparam [4:0] V_TI = 5'h10;

  // derived, never stored: only codes 001..011 enable the unit
  assign line_iface_enabled = ~line_mode_field[2] &
    (line_mode_field[1:0] != 2'h0);

  // loopback decode
  wire lb_line = (loopback_select == `LB_LINE);
  wire lb_pay = (loopback_select == `LB_PAYLOAD);
  wire lb_diag = (loopback_select == `LB_DIAG);
  wire lb_ldiag = (loopback_select == `LB_LINE_DIAG);
  wire lb_ana = (loopback_select == `LB_ANALOG);
  // receive-side input pin, only usable when the line unit is off
  wire [4:0] rl_or_none = line_iface_enabled ? V_NONE : V_RL;
  // transmit input pin, only when the rate adapter is bypassed
  wire [4:0] ti_or_none = rate_adapter_bypass ? V_TI : V_NONE;
  // recovered clock source when the receive side drives the clock
  wire [1:0] rx_src = line_iface_enabled ? `SRC_RX_LINE_UNIT :
    `SRC_RX_LINE_CLK_IN;
  wire [1:0] tx_src = rate_adapter_bypass ? `SRC_TX_CLK_IN :
    `SRC_RATE_ADAPTER;
  // all three output clocks for framer groups
  wire all_three = loop_timed | lb_pay | lb_diag |
    (lb_ana & ~line_iface_enabled);

  // receive line group: only its own input clock, and none with unit on
  assign rx_line_valid = rl_or_none;

  // transmit line group
  always @* begin
    if (tx_line_timing_sel) begin
      if (loop_timed | lb_line | lb_pay | lb_ldiag)
        tx_line_valid = rl_or_none;
      else
        tx_line_valid = ti_or_none;
    end else if (loop_timed | lb_diag) begin
      tx_line_valid = V_TL | V_TO | V_RO;
    end else if (lb_line | lb_pay) begin
      tx_line_valid = V_TL | V_RO;
    end else if (lb_ldiag) begin
      tx_line_valid = V_TL;
    end else begin
      tx_line_valid = V_TL | V_TO;
    end
  end

  // transmit framer group
  always @* begin
    if (tx_framer_timing_sel) begin
      if (loop_timed | lb_pay)
        tx_framer_valid = rl_or_none;
      else
        tx_framer_valid = ti_or_none;
    end else if (all_three) begin
      tx_framer_valid = V_TO | V_TL | V_RO;
    end else if (lb_ldiag) begin
      tx_framer_valid = V_TO | V_RO;
    end else if (lb_line) begin
      tx_framer_valid = V_TO;
    end else begin
      tx_framer_valid = V_TO | V_TL;
    end
  end

  // receive framer group
  always @* begin
    if (rx_framer_timing_sel) begin
      if (~loop_timed & (lb_diag | lb_ldiag))
        rx_framer_valid = ti_or_none;
      else
        rx_framer_valid = rl_or_none;
    end else if (all_three) begin
      rx_framer_valid = V_RO | V_TL | V_TO;
    end else if (lb_ldiag) begin
      rx_framer_valid = V_RO | V_TO;
    end else if (lb_line) begin
      rx_framer_valid = V_RO | V_TL;
    end else begin
      rx_framer_valid = V_RO;
    end
  end

  // functional sources: each data group follows its output clock pin
  always @* begin
    if (loop_timed | lb_line | lb_pay | lb_ldiag)
      tx_line_src = rx_src;
    else
      tx_line_src = tx_src;
    if (loop_timed | lb_pay)
      tx_framer_src = rx_src;
    else
      tx_framer_src = tx_src;
    if (loop_timed)
      rx_framer_src = rx_src;
    else if (loopback_select[2] | (lb_ana & ~line_iface_enabled))
      rx_framer_src = tx_src;
    else
      rx_framer_src = rx_src;
  end

endmodule // valid_ref_table
